// ===== logic/fps_pkg.sv
/*
  Package for the framer phase status and control block: register offsets,
  bit positions, reset values, count limits, carrier types, decode helpers.
  Assumes an 8-bit per-framer register offset space.
*/
package fps_pkg;

  // Register offsets within one framer
  localparam logic [7:0] FPS_OFS_SOFT_RESET = 8'h0d;
  localparam logic [7:0] FPS_OFS_PHASE_LOW  = 8'h0e;
  localparam logic [7:0] FPS_OFS_PHASE_HIGH = 8'h0f;
  localparam logic [7:0] FPS_OFS_RECOVERY   = 8'h10;

  // Field positions
  localparam int FPS_BIT_SOFT_RESET = 0;
  localparam int FPS_BIT_AMI        = 7;
  localparam int FPS_BIT_ALG_SEL    = 2;
  localparam int FPS_BIT_FRAME      = 0;

  // Reset values
  localparam logic FPS_RST_SOFT_RESET = 1'b0;
  localparam logic FPS_RST_AMI        = 1'b0;
  localparam logic FPS_RST_ALG_SEL    = 1'b0;

  // Last count position of a 125 us system frame
  localparam logic [7:0] FPS_COUNT_MAX_2M  = 8'hff;
  localparam logic [7:0] FPS_COUNT_MAX_1M5 = 8'hc0;

  // Nine-bit phase word
  typedef struct packed {
    logic       frame_bit;
    logic [7:0] count;
  } fps_phase_t;

  // Recovery configuration
  typedef struct packed {
    logic ami;
    logic alg_sel;
  } fps_cfg_t;

  // Top region of the channel field: 11X or 1X1
  function automatic logic fps_top_region(input logic [2:0] v);
    return v[2] & (v[1] | v[0]);
  endfunction

  // Frame bit flips when two captures straddle the frame edge
  function automatic logic fps_frame_toggle(input logic [2:0] prev,
                                            input logic [2:0] cur);
    return ((prev == 3'h0) && fps_top_region(cur)) ||
           (fps_top_region(prev) && (cur == 3'h0));
  endfunction

  // Either phase word address
  function automatic logic fps_is_phase_addr(input logic [7:0] a);
    return (a == FPS_OFS_PHASE_LOW) || (a == FPS_OFS_PHASE_HIGH);
  endfunction

  // Last count position for the selected backplane rate
  function automatic logic [7:0] fps_count_max(input logic mode_2m);
    return mode_2m ? FPS_COUNT_MAX_2M : FPS_COUNT_MAX_1M5;
  endfunction

endpackage

// ===== logic/fps_phase_counter.sv
/*
  Backplane position counter: bit and channel position inside the
  system frame, clocked by sampled edges of the backplane receive clock.
  Assumes the backplane clock and frame pulse are synchronous to clk.
*/
`timescale 1ns/10ps
module fps_phase_counter (
  input  wire logic       clk,            // System clock
  input  wire logic       rst_n,          // Async reset, active low
  input  wire logic       hold,           // Standby, keeps counter idle
  input  wire logic       mode_2m,        // 1: 2.048 MHz, 0: 1.544 MHz
  input  wire logic       bp_clk,         // Backplane receive clock
  input  wire logic       bp_frame_pulse, // System frame pulse
  output logic [7:0]      count           // Position in system frame
);
  import fps_pkg::*;

  logic       bp_clk_d;
  logic       bp_edge;
  logic [7:0] next_count;

  assign bp_edge = bp_clk & ~bp_clk_d;

  ////////////////////////////////////////////////////////////////////////
  // One step per backplane clock, wrap at end of frame
  always_comb begin
    next_count = count;
    if (hold) begin
      next_count = 8'h00;
    end else if (bp_edge) begin
      // Wrap also from above the limit if the rate changed mid-frame
      if (bp_frame_pulse || (count >= fps_count_max(mode_2m))) begin
        next_count = 8'h00;
      end else begin
        next_count = 8'(count + 8'h01);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count    <= 8'h00;
      bp_clk_d <= 1'b0;
    end else begin
      count    <= next_count;
      bp_clk_d <= bp_clk;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_COUNT_RANGE: assert property (@(posedge clk) disable iff (!rst_n)
    count <= fps_count_max(mode_2m))
    else $error("phase count beyond frame end");

  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!rst_n)
    bp_edge && !hold && !bp_frame_pulse && count < fps_count_max(mode_2m)
    |=> count == 8'($past(count) + 8'h01))
    else $error("phase count did not advance");

endmodule // fps_phase_counter

// ===== logic/fps_phase_capture.sv
/*
  Phase word capture: latches the backplane position at each line frame
  pulse, keeps the frame bit, and holds a readable copy while frozen.
  Assumes the line frame pulse is synchronous to clk.
*/
`timescale 1ns/10ps
module fps_phase_capture (
  input  wire logic         clk,        // System clock
  input  wire logic         rst_n,      // Async reset, active low
  input  wire logic         hold,       // Standby, clears the word
  input  wire logic [7:0]   count,      // Backplane position
  input  wire logic         line_pulse, // Line frame pulse
  input  wire logic         frozen,     // Readable copy frozen
  output fps_pkg::fps_phase_t held      // Readable phase word
);
  import fps_pkg::*;

  logic       line_d;
  logic       line_edge;
  fps_phase_t live;
  fps_phase_t next_live;
  fps_phase_t next_held;

  assign line_edge = line_pulse & ~line_d;

  ////////////////////////////////////////////////////////////////////////
  // Live word tracks every pulse so a frame edge is never missed,
  // even while software has the readable copy frozen
  always_comb begin
    next_live = live;
    next_held = held;
    if (hold) begin
      next_live = '0;
      next_held = '0;
    end else if (line_edge) begin
      next_live.count     = count;
      next_live.frame_bit = live.frame_bit ^
        fps_frame_toggle(live.count[7:5], count[7:5]);
      if (!frozen) begin
        next_held = next_live;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      live   <= '0;
      held   <= '0;
      line_d <= 1'b0;
    end else begin
      live   <= next_live;
      held   <= next_held;
      line_d <= line_pulse;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  AST_CAPTURE: assert property (@(posedge clk) disable iff (!rst_n)
    line_edge && !hold |=> live.count == $past(count))
    else $error("captured phase differs from position");

  AST_TOGGLE: assert property (@(posedge clk) disable iff (!rst_n)
    line_edge && !hold |=> live.frame_bit == ($past(live.frame_bit) ^
      fps_frame_toggle($past(live.count[7:5]), $past(count[7:5]))))
    else $error("frame bit wrong after capture");

  AST_REFRESH: assert property (@(posedge clk) disable iff (!rst_n)
    line_edge && !hold && !frozen |=> held == live)
    else $error("readable word not refreshed");

  AST_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
    frozen && !hold |=> $stable(held))
    else $error("frozen word changed");

endmodule // fps_phase_capture

// ===== logic/fps_framer_phase_status_control.sv
/*
  Per-framer control and status: software reset and standby, phase
  status word with freeze and release, recovery configuration bits.
  Assumes a register port with one-cycle strobes, read data one cycle
  later, and backplane and line timing synchronous to clk.
  The port never stalls and its two strobes are never high together.
  Only the offset within one framer arrives here; the framer select
  is decoded outside this block.
  The backplane rate should change only while the position counter is
  below the 1.544 MHz limit, or the range check will flag it.
*/
// Function
// - Software reset bit set keeps the framer held in reset
// - Reset bit never clears itself; only a written zero or a hardware reset releases it
// - Hardware reset clears the software reset bit
// - Framer in software reset sits idle in low-power standby
// - Backplane clock drives timing; mode bit picks 2.048 or 1.544 MHz
// - Low phase byte counts backplane clocks, 0-255 or 0-192
// - Count bits 7:3 give channel, bits 2:0 give bit in channel
// - Captured value is the position at the line frame pulse
// - Faster line clock gives falling values, slower gives rising
// - Ninth bit toggles only between 000 and 11X or 1X1
// - Both phase registers refresh each line frame pulse unless frozen
// - Writing either phase address freezes the word
// - Reading the low phase byte releases the freeze
// - Line-code bit 7 picks AMI when 1, B8ZS when 0
// - Bit 2 picks recovery algorithm, above or below 20 kHz
`timescale 1ns/10ps
module fps_framer_phase_status_control (
  input  wire logic       clk,                  // System clock, 25 MHz
  input  wire logic       rst_n,                // Async reset, active low

  input  wire logic [7:0] addr,                 // Register offset
  input  wire logic [7:0] wr_data,              // Write data
  input  wire logic       wr_strobe,            // Write strobe
  input  wire logic       rd_strobe,            // Read strobe
  output logic [7:0]      rd_data,              // Read data, next cycle

  input  wire logic       backplane_2m_select,  // Backplane rate select
  input  wire logic       backplane_receive_clock, // Backplane clock
  input  wire logic       backplane_frame_pulse,   // System frame pulse
  input  wire logic       line_frame_pulse,     // Line frame pulse

  output logic            framer_standby,       // Framer held in reset
  output logic            ami_line_code_select, // 1: AMI, 0: B8ZS
  output logic            recovery_algorithm_select, // Recovery algorithm
  output logic            phase_frozen          // Phase word frozen
);
  import fps_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Declarations

  // Control state and its next values
  logic       soft_reset;
  logic       next_soft_reset;
  fps_cfg_t   cfg;
  fps_cfg_t   next_cfg;
  logic       frozen;
  logic       next_frozen;
  logic       mode_2m;
  logic [7:0] next_rd_data;

  // Phase path between the two submodules
  logic [7:0] bp_count;
  fps_phase_t held;

  // Strobes qualified by offset
  logic       wr_reset;
  logic       wr_recovery;
  logic       wr_phase;
  logic       rd_phase_low;
  logic       rd_unmapped;

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  // Any offset this block answers; others read as zero
  function automatic logic is_mapped(input logic [7:0] a);
    return (a == FPS_OFS_SOFT_RESET) || (a == FPS_OFS_RECOVERY) ||
           fps_is_phase_addr(a);
  endfunction

  assign wr_reset     = wr_strobe && (addr == FPS_OFS_SOFT_RESET);
  assign wr_recovery  = wr_strobe && (addr == FPS_OFS_RECOVERY);
  assign wr_phase     = wr_strobe && fps_is_phase_addr(addr);
  assign rd_phase_low = rd_strobe && (addr == FPS_OFS_PHASE_LOW);
  assign rd_unmapped  = rd_strobe && !is_mapped(addr);

  ////////////////////////////////////////////////////////////////////////
  // Control register next values
  // A written zero or a hardware reset ends standby; the freeze flag and
  // the configuration are kept through standby

  always_comb begin
    next_soft_reset = soft_reset;
    next_cfg        = cfg;
    next_frozen     = frozen;

    // Only a software write moves the bit, never the framer itself
    if (wr_reset) begin
      next_soft_reset = wr_data[FPS_BIT_SOFT_RESET];
    end

    // Configuration survives standby so setup is not lost
    if (wr_recovery) begin
      next_cfg.ami     = wr_data[FPS_BIT_AMI];
      next_cfg.alg_sel = wr_data[FPS_BIT_ALG_SEL];
    end

    // Freeze set by any phase write, data value unused;
    // release on low byte read, so high byte must be read first
    if (wr_phase) begin
      next_frozen = 1'b1;
    end else if (rd_phase_low) begin
      next_frozen = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data mux; unmapped offsets and unused bits read as zero
  // Registered, so a read never loads the port combinationally

  always_comb begin
    next_rd_data = 8'h00;
    if (rd_strobe) begin
      case (addr)
        FPS_OFS_SOFT_RESET: begin
          next_rd_data[FPS_BIT_SOFT_RESET] = soft_reset;
        end
        FPS_OFS_PHASE_LOW: begin
          next_rd_data = held.count;
        end
        FPS_OFS_PHASE_HIGH: begin
          next_rd_data[FPS_BIT_FRAME] = held.frame_bit;
        end
        FPS_OFS_RECOVERY: begin
          next_rd_data[FPS_BIT_AMI]     = cfg.ami;
          next_rd_data[FPS_BIT_ALG_SEL] = cfg.alg_sel;
        end
        default: begin
          next_rd_data = 8'h00;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registers; hardware reset clears software reset too
  // Outputs load from the next values, so they come straight from
  // flip-flops yet change on the same edge as the state they mirror

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      soft_reset                <= FPS_RST_SOFT_RESET;
      cfg.ami                   <= FPS_RST_AMI;
      cfg.alg_sel               <= FPS_RST_ALG_SEL;
      frozen                    <= 1'b0;
      mode_2m                   <= 1'b0;
      rd_data                   <= 8'h00;
      framer_standby            <= 1'b0;
      ami_line_code_select      <= 1'b0;
      recovery_algorithm_select <= 1'b0;
      phase_frozen              <= 1'b0;
    end else begin
      soft_reset                <= next_soft_reset;
      cfg                       <= next_cfg;
      frozen                    <= next_frozen;
      mode_2m                   <= backplane_2m_select;
      rd_data                   <= next_rd_data;
      framer_standby            <= next_soft_reset;
      ami_line_code_select      <= next_cfg.ami;
      recovery_algorithm_select <= next_cfg.alg_sel;
      phase_frozen              <= next_frozen;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Phase measurement; held idle in standby to save power
  // Both submodules clear every cycle of standby and stay quiet
  // until the framer is released

  fps_phase_counter u_counter (
    .clk            (clk),
    .rst_n          (rst_n),
    .hold           (soft_reset),
    .mode_2m        (mode_2m),
    .bp_clk         (backplane_receive_clock),
    .bp_frame_pulse (backplane_frame_pulse),
    .count          (bp_count)
  );

  fps_phase_capture u_capture (
    .clk        (clk),
    .rst_n      (rst_n),
    .hold       (soft_reset),
    .count      (bp_count),
    .line_pulse (line_frame_pulse),
    .frozen     (frozen),
    .held       (held)
  );

  ////////////////////////////////////////////////////////////////////////
  // Checks

  AST_RESET_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_reset |=> framer_standby == $past(wr_data[FPS_BIT_SOFT_RESET]))
    else $error("standby does not follow written reset bit");

  AST_RESET_STICKY: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_reset |=> $stable(framer_standby))
    else $error("software reset bit changed on its own");

  AST_HW_RESET: assert property (@(posedge clk)
    $rose(rst_n) |-> !framer_standby && !soft_reset)
    else $error("software reset set after hardware reset");

  AST_STANDBY_IDLE: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset ##1 soft_reset |-> bp_count == 8'h00 && held == '0)
    else $error("framer logic active in standby");

  AST_FREEZE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_phase |=> phase_frozen ##1 (phase_frozen || $past(rd_phase_low)))
    else $error("phase write did not freeze");

  AST_RELEASE: assert property (@(posedge clk) disable iff (!rst_n)
    rd_phase_low && !wr_phase |=> !phase_frozen)
    else $error("low byte read did not release freeze");

  AST_READ_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    rd_phase_low |=> rd_data == $past(held.count))
    else $error("low byte read mismatch");

  AST_READ_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && addr == FPS_OFS_PHASE_HIGH
    |=> rd_data == {7'h00, $past(held.frame_bit)})
    else $error("high byte read mismatch");

  AST_AMI: assert property (@(posedge clk) disable iff (!rst_n)
    wr_recovery |=> ami_line_code_select == $past(wr_data[FPS_BIT_AMI]))
    else $error("line code select not updated");

  AST_ALG: assert property (@(posedge clk) disable iff (!rst_n)
    wr_recovery |=> recovery_algorithm_select ==
      $past(wr_data[FPS_BIT_ALG_SEL]) ##1 $stable(recovery_algorithm_select)
      || $past(wr_recovery))
    else $error("algorithm select not updated or not held");

  AST_PHASE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_phase && !soft_reset |=> $stable(soft_reset) && $stable(cfg))
    else $error("phase write disturbed other registers");

  AST_READ_ONE_CYCLE: assert property (@(posedge clk) disable iff (!rst_n)
    !rd_strobe |=> rd_data == 8'h00)
    else $error("read data stands beyond its cycle");

  // Read-back of the control registers and of unmapped offsets
  AST_RD_RESET: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && addr == FPS_OFS_SOFT_RESET
    |=> rd_data == {7'h00, $past(soft_reset)})
    else $error("reset bit read mismatch");

  AST_RD_RECOVERY: assert property (@(posedge clk) disable iff (!rst_n)
    rd_strobe && addr == FPS_OFS_RECOVERY
    |=> rd_data[FPS_BIT_AMI] == $past(cfg.ami) &&
        rd_data[FPS_BIT_ALG_SEL] == $past(cfg.alg_sel))
    else $error("recovery configuration read mismatch");

  AST_RD_UNMAPPED: assert property (@(posedge clk) disable iff (!rst_n)
    rd_unmapped |=> rd_data == 8'h00)
    else $error("unmapped offset read nonzero");

  // Control outputs hold between writes
  AST_CFG_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_recovery |=> $stable(ami_line_code_select) &&
      $stable(recovery_algorithm_select))
    else $error("configuration changed without a write");

  AST_STANDBY_KEPT: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset && !wr_reset |=> framer_standby)
    else $error("framer left standby without a write");

  AST_RELEASE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
    wr_reset && !wr_data[FPS_BIT_SOFT_RESET] |=> !framer_standby)
    else $error("written zero did not release the framer");

  AST_PHASE_OUTS: assert property (@(posedge clk) disable iff (!rst_n)
    wr_phase |=> $stable(framer_standby) && $stable(ami_line_code_select))
    else $error("phase write moved a control output");

  // Freeze flag and frozen word
  AST_FREEZE_HOLD: assert property (@(posedge clk) disable iff (!rst_n)
    !wr_phase && !rd_phase_low |=> $stable(phase_frozen))
    else $error("freeze flag moved without a phase access");

  AST_WORD_FROZEN: assert property (@(posedge clk) disable iff (!rst_n)
    phase_frozen && !soft_reset |=> $stable(held))
    else $error("frozen phase word changed");

  // Standby reads back a cleared phase word
  AST_STANDBY_LOW: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset && $past(soft_reset) && rd_phase_low |=> rd_data == 8'h00)
    else $error("phase low byte not cleared in standby");

  AST_STANDBY_HIGH: assert property (@(posedge clk) disable iff (!rst_n)
    soft_reset && $past(soft_reset) && rd_strobe && addr == FPS_OFS_PHASE_HIGH
    |=> rd_data == 8'h00)
    else $error("phase high byte not cleared in standby");

  AST_HW_RESET_OUTS: assert property (@(posedge clk)
    $rose(rst_n) |-> !phase_frozen && !ami_line_code_select && rd_data == 8'h00)
    else $error("outputs not cleared by hardware reset");

endmodule // fps_framer_phase_status_control

// ===== bench/fps_framer_phase_status_control_tb.sv
/*
  Self-checking bench for the framer phase status and control block:
  register port tasks, backplane and line timing stimulus, phase reads.
  Assumes the register port timing and count behaviour of the hand-over.
*/
`timescale 1ns/10ps
module fps_framer_phase_status_control_tb;
  import fps_pkg::*;

  logic       clk;
  logic       rst_n;
  logic [7:0] addr;
  logic [7:0] wr_data;
  logic       wr_strobe;
  logic       rd_strobe;
  logic [7:0] rd_data;
  logic       bp_2m;
  logic       bp_clk;
  logic       bp_fp;
  logic       line_fp;
  logic       standby;
  logic       ami;
  logic       alg;
  logic       frozen;
  int         n_fail;
  int         n_tests;
  logic [7:0] exp_cnt;
  logic       exp_fb;
  logic [7:0] v;
  logic [7:0] snap;
  int         ns_tab[5];
  logic [7:0] cfg_tab[4];

  fps_framer_phase_status_control u_dut (
    .clk                       (clk),
    .rst_n                     (rst_n),
    .addr                      (addr),
    .wr_data                   (wr_data),
    .wr_strobe                 (wr_strobe),
    .rd_strobe                 (rd_strobe),
    .rd_data                   (rd_data),
    .backplane_2m_select       (bp_2m),
    .backplane_receive_clock   (bp_clk),
    .backplane_frame_pulse     (bp_fp),
    .line_frame_pulse          (line_fp),
    .framer_standby            (standby),
    .ami_line_code_select      (ami),
    .recovery_algorithm_select (alg),
    .phase_frozen              (frozen)
  );

  ////////////////////////////////////////////////////////////////////////////
  // 25 MHz system clock
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Comparison and closing report
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Hang guard: far above the longest expected run
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port: one-cycle strobes, read data the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr      <= a;
    wr_data   <= d;
    wr_strobe <= 1'b1;
    @(posedge clk);
    wr_strobe <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    addr      <= a;
    rd_strobe <= 1'b1;
    @(posedge clk);
    rd_strobe <= 1'b0;
    #1;
    d = rd_data;
  endtask

  // Settled view of outputs one edge later
  task automatic settle();
    @(posedge clk);
    #1;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Timing stimulus: backplane edges three clk apart, slower than clk/2
  task automatic bp_edge(input logic fp);
    @(posedge clk);
    bp_clk <= 1'b1;
    bp_fp  <= fp;
    @(posedge clk);
    @(posedge clk);
    bp_clk <= 1'b0;
    bp_fp  <= 1'b0;
  endtask

  function automatic logic top_zone(input logic [2:0] c);
    return (c == 3'h5) || (c == 3'h6) || (c == 3'h7);
  endfunction

  // Frame start, n backplane edges, then a line pulse; tracks expectation
  task automatic cap(input int n);
    logic [7:0] c;
    bp_edge(1'b1);
    repeat (n) bp_edge(1'b0);
    @(posedge clk);
    line_fp <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    line_fp <= 1'b0;
    repeat (3) @(posedge clk);
    c = bp_2m ? 8'(n % 256) : 8'(n % 193);
    if (((exp_cnt[7:5] == 3'h0) && top_zone(c[7:5])) ||
        (top_zone(exp_cnt[7:5]) && (c[7:5] == 3'h0))) begin
      exp_fb = ~exp_fb;
    end
    exp_cnt = c;
  endtask

  // Freeze, read high then low, release; write data must not matter
  task automatic rdphase(input logic [7:0] a, input logic [7:0] cnt, input logic fb);
    wr(a, 8'ha5);
    settle();
    chk({7'h0, frozen}, 8'h01);
    rd(FPS_OFS_PHASE_HIGH, v);
    chk(v, {7'h0, fb});
    rd(FPS_OFS_PHASE_LOW, v);
    chk(v, cnt);
    settle();
    chk({7'h0, frozen}, 8'h00);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    n_fail = 0; n_tests = 0; exp_cnt = 8'h00; exp_fb = 1'b0;
    rst_n = 1'b0; addr = 8'h00; wr_data = 8'h00; wr_strobe = 1'b0;
    rd_strobe = 1'b0; bp_2m = 1'b1; bp_clk = 1'b0; bp_fp = 1'b0;
    line_fp = 1'b0;
    ns_tab  = '{10, 250, 5, 100, 200};
    cfg_tab = '{8'h80, 8'h04, 8'hff, 8'h00};
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk({4'h0, standby, ami, alg, frozen}, 8'h00);
    rd(FPS_OFS_SOFT_RESET, v);
    chk(v, 8'h00);
    rd(8'h20, v);
    chk(v, 8'h00);
    // Every line-code and algorithm setting
    foreach (cfg_tab[i]) begin
      wr(FPS_OFS_RECOVERY, cfg_tab[i]);
      rd(FPS_OFS_RECOVERY, v);
      chk(v, cfg_tab[i] & 8'h84);
      chk({7'h0, ami}, {7'h0, cfg_tab[i][7]});
      chk({7'h0, alg}, {7'h0, cfg_tab[i][2]});
    end
    // Captures across the frame edge, alternating freeze address
    foreach (ns_tab[i]) begin
      cap(ns_tab[i]);
      rdphase(i[0] ? FPS_OFS_PHASE_HIGH : FPS_OFS_PHASE_LOW, exp_cnt, exp_fb);
    end
    // Line faster than system: positions fall
    for (int k = 0; k < 3; k++) begin
      cap(120 - k);
      rdphase(FPS_OFS_PHASE_LOW, exp_cnt, exp_fb);
    end
    // Slower backplane: last position 192, then wrap
    @(posedge clk);
    bp_2m <= 1'b0;
    cap(192);
    rdphase(FPS_OFS_PHASE_LOW, exp_cnt, exp_fb);
    cap(194);
    rdphase(FPS_OFS_PHASE_HIGH, exp_cnt, exp_fb);
    @(posedge clk);
    bp_2m <= 1'b1;
    cap(255);
    rdphase(FPS_OFS_PHASE_LOW, exp_cnt, exp_fb);
    // Frozen word survives a later line pulse
    cap(40);
    snap = exp_cnt;
    wr(FPS_OFS_PHASE_LOW, 8'hff);
    cap(60);
    rd(FPS_OFS_PHASE_HIGH, v);
    chk(v, 8'h00);
    rd(FPS_OFS_PHASE_LOW, v);
    chk(v, snap);
    settle();
    chk({7'h0, frozen}, 8'h00);
    cap(70);
    rdphase(FPS_OFS_PHASE_LOW, exp_cnt, exp_fb);
    // Software reset holds, clears the word, and is not self-clearing
    wr(FPS_OFS_SOFT_RESET, 8'hff);
    rd(FPS_OFS_SOFT_RESET, v);
    chk(v, 8'h01);
    cap(30);
    repeat (50) @(posedge clk);
    chk({7'h0, standby}, 8'h01);
    rdphase(FPS_OFS_PHASE_LOW, 8'h00, 1'b0);
    chk({7'h0, ami}, 8'h00);
    wr(FPS_OFS_SOFT_RESET, 8'h00);
    settle();
    chk({7'h0, standby}, 8'h00);
    exp_cnt = 8'h00;
    exp_fb  = 1'b0;
    cap(33);
    rdphase(FPS_OFS_PHASE_HIGH, exp_cnt, exp_fb);
    // Hardware reset in mid-run clears the held software reset
    wr(FPS_OFS_SOFT_RESET, 8'h01);
    settle();
    chk({7'h0, standby}, 8'h01);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    settle();
    chk({7'h0, standby}, 8'h00);
    rd(FPS_OFS_SOFT_RESET, v);
    chk(v, 8'h00);
    print_verdict();
  end

endmodule // fps_framer_phase_status_control_tb
